// ==== include/mid_pkg.sv ====
// constants, opcode patterns and state type for the instruction decoder core
package mid_pkg;
    // widths
    localparam int IW = 14;              // instruction word
    localparam int PCW = 12;             // program address
    localparam int DW = 8;               // data byte
    localparam int STK = 8;              // return stack entries
    localparam int SPW = 3;              // stack pointer width

    // six-bit opcode prefixes, word bits 13..8
    localparam logic [5:0] OP_ROTL = 6'h0d;
    localparam logic [5:0] OP_ROTR = 6'h0c;
    localparam logic [5:0] OP_SUBF = 6'h02;
    localparam logic [5:0] OP_SWAP = 6'h0e;
    localparam logic [5:0] OP_XORF = 6'h06;
    localparam logic [5:0] OP_ADDL = 6'h1c;
    localparam logic [5:0] OP_ANDL = 6'h1d;
    localparam logic [5:0] OP_JUMP = 6'h3a;
    localparam logic [5:0] OP_ORL = 6'h1a;
    localparam logic [5:0] OP_LDL = 6'h19;
    localparam logic [5:0] OP_RETL = 6'h18;
    localparam logic [5:0] OP_XORL = 6'h1f;
    // seven-bit prefixes, bits 13..7
    localparam logic [6:0] OP_COPY_WORK_TO_FILE = 7'h01;
    localparam logic [6:0] OP_ZERO_TEST_FILE = 7'h11;
    // eight-bit prefix, bits 13..6
    localparam logic [7:0] OP_COPY_WORK_TO_SECOND_PLANE = 8'h00;
    // bit-oriented prefixes, bits 13..9; bit number sits in 8..6
    localparam logic [4:0] OP_BCLR = 5'h08;
    localparam logic [4:0] OP_BSET = 5'h09;
    localparam logic [4:0] OP_BTLO = 5'h0a;
    localparam logic [4:0] OP_BTHI = 5'h0b;
    // call prefix, bits 13..12
    localparam logic [1:0] OP_CALL = 2'h2;
    // fixed words
    localparam logic [13:0] W_NOP = 14'h0000;
    localparam logic [13:0] W_SLEEP = 14'h0003;
    localparam logic [13:0] W_WDT = 14'h0004;
    localparam logic [13:0] W_RET = 14'h0040;
    localparam logic [13:0] W_INTERRUPT_RETURN = 14'h0060;
    localparam logic [13:0] W_TABH = 14'h0058;

    // status bit positions and reset value
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int ST_PD = 3;
    localparam int ST_TO = 4;
    localparam int ST_GIE = 5;
    localparam logic [7:0] STAT_RST = 8'h18;

    // register port offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_WORK = 8'h08;
    localparam logic [7:0] REG_PCLO = 8'h0c;
    localparam logic [7:0] REG_PCHI = 8'h10;
    localparam logic [7:0] REG_TABLO = 8'h14;
    localparam logic [7:0] REG_TABHI = 8'h18;
    localparam int CTRL_RUN = 0;

    // sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_WAIT = 4'b0001,
        ST_RUN = 4'b0010,
        ST_TBL = 4'b0100,
        ST_SLEEP = 4'b1000
    } mid_state_e;
endpackage

// ==== hdl/mid_core.sv ====
// instruction decoder and executor core for a 14-bit word microcontroller
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - copy work to file register, no flags
// - copy work to second plane register
// - rotate file through carry, carry only
// - subtract work from file, C DC Z
// - swap file nibbles, no flags
// - xor work with file, Z
// - clear or set one file bit
// - bit test skip, one or two cycles
// - add literal to work, C DC Z
// - and literal into work, Z
// - call 12-bit target, two cycles
// - watchdog restart, sets timeout/powerdown flags
// - jump to branch target, two cycles
// - or literal into work, Z
// - load literal into work, no flags
// - all-zero word does nothing
// - subroutine/interrupt return, two cycles
// - return loading literal into work
// - power-down, oscillator stop, flags updated
// - xor literal into work, Z
// - table read high part, two cycles
// - one 14-bit word per instruction
// - destination bit picks work or file
// - call pushes next address, loads target
module mid_core (
    input wire logic mclk,
    input wire logic sys_rst,
    output logic [11:0] pmAddr,        // program fetch address
    input wire logic [13:0] pmData,    // word at last cycle's pmAddr
    output logic [11:0] tblAddr,       // table lookup address
    input wire logic [13:0] tblData,   // word at last cycle's tblAddr
    input wire logic wakeUp,           // ends power-down
    output logic wdtRestart,           // one-cycle watchdog clear
    output logic powerDown,            // oscillator halt request
    input wire logic [7:0] busAddr,
    input wire logic [7:0] busWdata,
    input wire logic busWr,
    input wire logic busRd,
    output logic [7:0] busRdata
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    mid_pkg::mid_state_e state_r, state_nxt;
    logic [11:0] pmAddr_r, pmAddr_nxt;   // leads execution by one word
    logic [11:0] curAddr_r;              // address of word in pmData
    logic [7:0] wReg_r, wReg_nxt;        // working register
    logic [7:0] stat_r, stat_nxt;        // status flags
    logic [2:0] sp_r, sp_nxt;            // next free stack slot
    logic runEn_r;                       // software run gate
    logic [11:0] tabPtr_r;               // table pointer
    logic wdtRestart_r, powerDown_r;
    logic [7:0] busRdata_r;
    logic [7:0] fMem [0:127];            // file plane
    logic [7:0] rMem [0:63];             // second plane
    logic [11:0] stack [0:7];            // return addresses
    logic fWe, rWe, push, wdtHit;
    logic [6:0] fWa;
    logic [7:0] fWd;
    ////////////////////////////////////////////////////////////////////////////
    // field extraction, whole word decoded at once
    wire [13:0] iw = pmData;
    wire exec = (state_r == mid_pkg::ST_RUN) && runEn_r;
    wire [5:0] op6 = iw[13:8];
    wire [6:0] fAddr = iw[6:0];
    wire [5:0] bAddr = iw[5:0];
    wire [5:0] rAddr = iw[5:0];
    wire [2:0] bitNo = iw[8:6];                               // bit ops keep 13..9 as opcode
    wire [7:0] lit = iw[7:0];
    wire [11:0] lit12 = iw[11:0];
    wire dest = iw[7];
    // fixed words first: no-op, sleep and watchdog share the second-plane pattern
    wire isNop = iw == mid_pkg::W_NOP;
    wire isSleep = iw == mid_pkg::W_SLEEP;
    wire isWdt = iw == mid_pkg::W_WDT;
    wire isRet = iw == mid_pkg::W_RET;
    wire isReti = iw == mid_pkg::W_INTERRUPT_RETURN;
    wire isTabh = iw == mid_pkg::W_TABH;
    wire isFixed = isNop | isSleep | isWdt;
    wire isMovwf = iw[13:7] == mid_pkg::OP_COPY_WORK_TO_FILE;
    wire isMovwr = (iw[13:6] == mid_pkg::OP_COPY_WORK_TO_SECOND_PLANE) && !isFixed;
    wire isTestz = iw[13:7] == mid_pkg::OP_ZERO_TEST_FILE;
    wire isRotl = op6 == mid_pkg::OP_ROTL;
    wire isRotr = op6 == mid_pkg::OP_ROTR;
    wire isSubf = op6 == mid_pkg::OP_SUBF;
    wire isSwap = op6 == mid_pkg::OP_SWAP;
    wire isXorf = op6 == mid_pkg::OP_XORF;
    // five-bit match: a four-bit one would merge clear with set and low test with high test
    wire isBclr = iw[13:9] == mid_pkg::OP_BCLR;
    wire isBset = iw[13:9] == mid_pkg::OP_BSET;
    wire isBtlo = iw[13:9] == mid_pkg::OP_BTLO;
    wire isBthi = iw[13:9] == mid_pkg::OP_BTHI;
    wire isAddl = op6 == mid_pkg::OP_ADDL;
    wire isAndl = op6 == mid_pkg::OP_ANDL;
    wire isOrl = op6 == mid_pkg::OP_ORL;
    wire isXorl = op6 == mid_pkg::OP_XORL;
    wire isLdl = op6 == mid_pkg::OP_LDL;
    wire isRetl = op6 == mid_pkg::OP_RETL;
    wire isJump = op6 == mid_pkg::OP_JUMP;
    wire isCall = iw[13:12] == mid_pkg::OP_CALL;
    wire isByte = isRotl | isRotr | isSubf | isSwap | isXorf;
    ////////////////////////////////////////////////////////////////////////////
    // datapath
    wire [7:0] fVal = fMem[fAddr];
    wire [7:0] bVal = fMem[{1'b0, bAddr}];
    wire cIn = stat_r[mid_pkg::ST_C];
    // subtract as f + ~w + 1, so carry set means no borrow
    wire [8:0] subSum = {1'b0, fVal} + {1'b0, ~wReg_r} + 9'h001;
    wire [4:0] subNib = {1'b0, fVal[3:0]} + {1'b0, ~wReg_r[3:0]} + 5'h01;
    wire [8:0] addSum = {1'b0, wReg_r} + {1'b0, lit};
    wire [4:0] addNib = {1'b0, wReg_r[3:0]} + {1'b0, lit[3:0]};
    wire [7:0] rotlVal = {fVal[6:0], cIn};
    wire [7:0] rotrVal = {cIn, fVal[7:1]};
    wire [7:0] swapVal = {fVal[3:0], fVal[7:4]};
    wire [7:0] byteRes = isRotl ? rotlVal :
                         isRotr ? rotrVal :
                         isSwap ? swapVal :
                         isSubf ? subSum[7:0] : (fVal ^ wReg_r);
    wire [7:0] bitMask = 8'h01 << bitNo;
    wire bitVal = bVal[bitNo];
    wire doSkip = (isBtlo & !bitVal) | (isBthi & bitVal);
    wire [11:0] seqAddr = curAddr_r + 12'h001;
    wire [11:0] stackTop = stack[sp_r - 3'h1];
    ////////////////////////////////////////////////////////////////////////////
    // next-state and execute
    always_comb begin
        state_nxt = state_r;
        pmAddr_nxt = pmAddr_r;
        wReg_nxt = wReg_r;
        stat_nxt = stat_r;
        sp_nxt = sp_r;
        fWe = 1'b0;
        fWa = fAddr;
        fWd = 8'h00;
        rWe = 1'b0;
        push = 1'b0;
        wdtHit = 1'b0;
        case (state_r)
            mid_pkg::ST_WAIT: begin
                // discard the word in flight, fetch on
                if (runEn_r) begin
                    pmAddr_nxt = pmAddr_r + 12'h001;
                    state_nxt = mid_pkg::ST_RUN;
                end
            end
            mid_pkg::ST_TBL: begin
                // second cycle: table high part lands in work
                wReg_nxt = {2'b00, tblData[13:8]};
                pmAddr_nxt = pmAddr_r + 12'h001;
                state_nxt = mid_pkg::ST_RUN;
            end
            mid_pkg::ST_SLEEP: begin
                // clock stopped until woken; resume after the sleep word
                if (wakeUp) begin
                    state_nxt = mid_pkg::ST_WAIT;
                end
            end
            mid_pkg::ST_RUN: begin
                if (!runEn_r) begin
                    // halted: refetch the word that was not executed
                    pmAddr_nxt = curAddr_r;
                    state_nxt = mid_pkg::ST_WAIT;
                end else begin
                    pmAddr_nxt = pmAddr_r + 12'h001;
                    if (isMovwf) begin
                        fWe = 1'b1;
                        fWd = wReg_r;
                    end else if (isMovwr) begin
                        rWe = 1'b1;
                    end else if (isByte) begin
                        // destination bit: 0 work, 1 file
                        if (dest) begin
                            fWe = 1'b1;
                            fWd = byteRes;
                        end else begin
                            wReg_nxt = byteRes;
                        end
                        if (isRotl) begin
                            stat_nxt[mid_pkg::ST_C] = fVal[7];
                        end else if (isRotr) begin
                            stat_nxt[mid_pkg::ST_C] = fVal[0];
                        end else if (isSubf) begin
                            stat_nxt[mid_pkg::ST_C] = subSum[8];
                            stat_nxt[mid_pkg::ST_DC] = subNib[4];
                            stat_nxt[mid_pkg::ST_Z] = subSum[7:0] == 8'h00;
                        end else if (isXorf) begin
                            stat_nxt[mid_pkg::ST_Z] = byteRes == 8'h00;
                        end
                        // swap touches no flag
                    end else if (isTestz) begin
                        stat_nxt[mid_pkg::ST_Z] = fVal == 8'h00;
                    end else if (isBclr | isBset) begin
                        fWe = 1'b1;
                        fWa = {1'b0, bAddr};
                        fWd = isBset ? (bVal | bitMask) : (bVal & ~bitMask);
                    end else if (isBtlo | isBthi) begin
                        // skipped word is fetched but discarded
                        if (doSkip) begin
                            state_nxt = mid_pkg::ST_WAIT;
                        end
                    end else if (isAddl) begin
                        wReg_nxt = addSum[7:0];
                        stat_nxt[mid_pkg::ST_C] = addSum[8];
                        stat_nxt[mid_pkg::ST_DC] = addNib[4];
                        stat_nxt[mid_pkg::ST_Z] = addSum[7:0] == 8'h00;
                    end else if (isAndl) begin
                        wReg_nxt = wReg_r & lit;
                        stat_nxt[mid_pkg::ST_Z] = (wReg_r & lit) == 8'h00;
                    end else if (isOrl) begin
                        wReg_nxt = wReg_r | lit;
                        stat_nxt[mid_pkg::ST_Z] = (wReg_r | lit) == 8'h00;
                    end else if (isXorl) begin
                        wReg_nxt = wReg_r ^ lit;
                        stat_nxt[mid_pkg::ST_Z] = (wReg_r ^ lit) == 8'h00;
                    end else if (isLdl) begin
                        wReg_nxt = lit;
                    end else if (isCall) begin
                        push = 1'b1;
                        sp_nxt = sp_r + 3'h1;
                        pmAddr_nxt = lit12;
                        state_nxt = mid_pkg::ST_WAIT;
                    end else if (isJump) begin
                        // page bits kept from the current address
                        pmAddr_nxt = {curAddr_r[11:8], lit};
                        state_nxt = mid_pkg::ST_WAIT;
                    end else if (isRet | isReti | isRetl) begin
                        sp_nxt = sp_r - 3'h1;
                        pmAddr_nxt = stackTop;
                        state_nxt = mid_pkg::ST_WAIT;
                        if (isReti) begin
                            stat_nxt[mid_pkg::ST_GIE] = 1'b1;
                        end
                        if (isRetl) begin
                            wReg_nxt = lit;
                        end
                    end else if (isWdt) begin
                        wdtHit = 1'b1;
                        stat_nxt[mid_pkg::ST_TO] = 1'b1;
                        stat_nxt[mid_pkg::ST_PD] = 1'b1;
                    end else if (isSleep) begin
                        stat_nxt[mid_pkg::ST_TO] = 1'b1;
                        stat_nxt[mid_pkg::ST_PD] = 1'b0;
                        pmAddr_nxt = seqAddr;
                        state_nxt = mid_pkg::ST_SLEEP;
                    end else if (isTabh) begin
                        // hold fetch so the next word lands after TBL
                        pmAddr_nxt = pmAddr_r;
                        state_nxt = mid_pkg::ST_TBL;
                    end
                    // all-zero and unmatched words fall through idle
                end
            end
            default: begin
                state_nxt = mid_pkg::ST_WAIT;
            end
        endcase
    end
    ////////////////////////////////////////////////////////////////////////////
    // register port decode
    wire wrCtrl = busWr && (busAddr == mid_pkg::REG_CTRL);
    wire wrTabLo = busWr && (busAddr == mid_pkg::REG_TABLO);
    wire wrTabHi = busWr && (busAddr == mid_pkg::REG_TABHI);
    wire [7:0] rdMux = (busAddr == mid_pkg::REG_CTRL) ? {7'h00, runEn_r} :
                       (busAddr == mid_pkg::REG_STATUS) ? stat_r :
                       (busAddr == mid_pkg::REG_WORK) ? wReg_r :
                       (busAddr == mid_pkg::REG_PCLO) ? curAddr_r[7:0] :
                       (busAddr == mid_pkg::REG_PCHI) ? {4'h0, curAddr_r[11:8]} :
                       (busAddr == mid_pkg::REG_TABLO) ? tabPtr_r[7:0] :
                       (busAddr == mid_pkg::REG_TABHI) ? {4'h0, tabPtr_r[11:8]} : 8'h00;
    ////////////////////////////////////////////////////////////////////////////
    // core registers
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= mid_pkg::ST_WAIT;
            pmAddr_r <= 12'h000;
            curAddr_r <= 12'h000;
            wReg_r <= 8'h00;
            stat_r <= mid_pkg::STAT_RST;
            sp_r <= 3'h0;
            wdtRestart_r <= 1'b0;
            powerDown_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            pmAddr_r <= pmAddr_nxt;
            curAddr_r <= pmAddr_r;
            wReg_r <= wReg_nxt;
            stat_r <= stat_nxt;
            sp_r <= sp_nxt;
            wdtRestart_r <= wdtHit;
            powerDown_r <= state_nxt == mid_pkg::ST_SLEEP;
        end
    end
    // software-facing registers; reads answer one cycle later
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            runEn_r <= 1'b0;
            tabPtr_r <= 12'h000;
            busRdata_r <= 8'h00;
        end else begin
            if (wrCtrl) begin
                runEn_r <= busWdata[mid_pkg::CTRL_RUN];
            end
            if (wrTabLo) begin
                tabPtr_r[7:0] <= busWdata;
            end
            if (wrTabHi) begin
                tabPtr_r[11:8] <= busWdata[3:0];
            end
            busRdata_r <= busRd ? rdMux : 8'h00;
        end
    end

    // storage arrays, no reset: contents are undefined after power-up
    always_ff @(posedge mclk) begin
        if (fWe) begin
            fMem[fWa] <= fWd;
        end
        if (rWe) begin
            rMem[rAddr] <= wReg_r;
        end
        if (push) begin
            stack[sp_r] <= seqAddr;
        end
    end

    assign pmAddr = pmAddr_r;
    assign tblAddr = tabPtr_r;
    assign wdtRestart = wdtRestart_r;
    assign powerDown = powerDown_r;
    assign busRdata = busRdata_r;
    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    a_copy_work_to_file_store: assert property (exec && isMovwf |=>
        fMem[$past(fAddr)] == $past(wReg_r) && $stable(stat_r)) else $error("copy to file register wrong");
    a_plane_store: assert property (exec && isMovwr |=>
        rMem[$past(rAddr)] == $past(wReg_r) && $stable(stat_r)) else $error("copy to second plane wrong");
    a_call_target: assert property (exec && isCall |=>
        pmAddr_r == $past(lit12) && state_r == mid_pkg::ST_WAIT && sp_r == $past(sp_r) + 3'h1)
        else $error("call did not branch and push");
    a_skip_stall: assert property (exec && doSkip |=>
        state_r == mid_pkg::ST_WAIT ##1 curAddr_r == $past(curAddr_r, 2) + 12'h002)
        else $error("bit test skip wrong");
    a_literal_load: assert property (exec && isLdl |=>
        wReg_r == $past(lit) && $stable(stat_r)) else $error("literal load wrong");
    a_and_zero: assert property (exec && isAndl |=>
        stat_r[mid_pkg::ST_Z] == (wReg_r == 8'h00) && stat_r[mid_pkg::ST_C] == $past(cIn))
        else $error("and literal zero flag wrong");
    a_sleep_enter: assert property (exec && isSleep |=>
        powerDown_r && !stat_r[mid_pkg::ST_PD] && stat_r[mid_pkg::ST_TO]) else $error("power-down entry wrong");
    a_return_pop: assert property (exec && isRet |=>
        pmAddr_r == $past(stackTop) && sp_r == $past(sp_r) - 3'h1) else $error("return did not pop");
    a_nop_idle: assert property (exec && isNop |=>
        $stable(wReg_r) && $stable(stat_r) && $stable(sp_r)) else $error("no-op changed state");

endmodule // mid_core

`default_nettype wire

// ==== sim/mid_prog_mem.sv ====
// program memory model: synchronous rom with a fetch port and a table port
`timescale 1ns/1ps
`default_nettype none
module mid_prog_mem (
    input wire logic mclk,
    input wire logic [11:0] pmAddr,
    output logic [13:0] pmData,
    input wire logic [11:0] tblAddr,
    output logic [13:0] tblData
);
    logic [13:0] mem [0:4095]; // word store, filled by the bench
    // one whole word per address, one cycle late as a real rom answers
    always @(posedge mclk) begin
        pmData <= mem[pmAddr];
        tblData <= mem[tblAddr];
    end
endmodule // mid_prog_mem
`default_nettype wire

// ==== sim/testbench.sv ====
// self-checking bench: programs run on the core, results read over the register port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic wakeUp = 1'b0;
    logic [7:0] busAddr = 8'h00;
    logic [7:0] busWdata = 8'h00;
    logic busWr = 1'b0;
    logic busRd = 1'b0;
    logic [11:0] pmAddr;
    logic [13:0] pmData;
    logic [11:0] tblAddr;
    logic [13:0] tblData;
    logic wdtRestart;
    logic powerDown;
    logic [7:0] busRdata;
    logic rdPend = 1'b0; // read answer due this cycle
    logic [7:0] expQ [$]; // expected read data, oldest first
    logic [7:0] wdtCount = 8'h00; // watchdog pulses seen
    logic [7:0] rnd;
    integer n_errors = 0;
    integer checked = 0;
    integer seed = 72;
    // main line and the code at 0x20; a skipped word would zero the work register
    logic [13:0] progA [0:12] = '{14'h193c, 14'h00a0, 14'h0e20, 14'h1d0f,
        14'h1cfe, 14'h0058, 14'h1f2a, 14'h2040, 14'h1a80,
        14'h1120, 14'h1520, 14'h1900, 14'h3a20};
    logic [13:0] progB [0:7] = '{14'h0004, 14'h0003, 14'h0e20, 14'h02a0,
        14'h0e20, 14'h0004, 14'h2041, 14'h3a27};
    always #2 mclk = ~mclk;
    mid_core u_mid_core (.mclk(mclk), .sys_rst(sys_rst), .pmAddr(pmAddr), .pmData(pmData),
        .tblAddr(tblAddr), .tblData(tblData), .wakeUp(wakeUp), .wdtRestart(wdtRestart),
        .powerDown(powerDown), .busAddr(busAddr), .busWdata(busWdata), .busWr(busWr),
        .busRd(busRd), .busRdata(busRdata));
    mid_prog_mem u_mid_prog_mem (.mclk(mclk), .pmAddr(pmAddr), .pmData(pmData),
        .tblAddr(tblAddr), .tblData(tblData));
    ////////////////////////////////////////////////////////////////////////////////
    // single comparison point
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one-cycle write strobe, then a low cycle so no signal is set twice at one edge
    task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        busWr <= 1'b1;
        busAddr <= a;
        busWdata <= d;
        @(posedge mclk);
        busWr <= 1'b0;
    endtask
    // read strobe; the monitor compares the answer a cycle later
    task automatic bus_read(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        busRd <= 1'b1;
        busAddr <= a;
        expQ.push_back(e);
        @(posedge mclk);
        busRd <= 1'b0;
    endtask
    // bounded wait on the power-down level
    task automatic wait_pd(input logic lvl);
        for (int i = 0; i < 400 && powerDown !== lvl; i++) @(posedge mclk);
        check({7'h00, powerDown}, {7'h00, lvl});
    endtask
    task automatic tally_and_finish;
        $display("counts: %0d checked, %0d mismatched", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // monitor: read data only in the answer cycle, zero elsewhere
    always @(posedge mclk) rdPend <= busRd;
    always @(negedge mclk) begin
        if (wdtRestart === 1'b1) wdtCount <= wdtCount + 8'h01;
        if (rdPend === 1'b1) check(busRdata, expQ.pop_front());
        else check(busRdata, 8'h00);
    end
    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (5000) @(posedge mclk);
        n_errors = n_errors + 1;
        tally_and_finish();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #1;
        for (int i = 0; i < 4096; i++) u_mid_prog_mem.mem[i] = 14'h0000;
        for (int i = 0; i < 13; i++) u_mid_prog_mem.mem[i] = progA[i];
        for (int i = 0; i < 8; i++) u_mid_prog_mem.mem[12'h020 + i] = progB[i];
        u_mid_prog_mem.mem[12'h040] = 14'h1877;
        // second subroutine: no-op at 0x41, plane copy, plain return
        u_mid_prog_mem.mem[12'h042] = 14'h0005;
        u_mid_prog_mem.mem[12'h043] = 14'h0040;
        u_mid_prog_mem.mem[12'h100] = 14'h2a55; // table entry, high part 0x2a
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        bus_read(mid_pkg::REG_STATUS, mid_pkg::STAT_RST);
        bus_read(mid_pkg::REG_WORK, 8'h00);
        $display("reset values done");
        rnd = 8'($random(seed));
        bus_write(mid_pkg::REG_TABLO, rnd);
        bus_read(mid_pkg::REG_TABLO, rnd);
        rnd = 8'($random(seed));
        bus_write(mid_pkg::REG_TABHI, rnd);
        bus_read(mid_pkg::REG_TABHI, rnd & 8'h0f);
        bus_write(mid_pkg::REG_STATUS, 8'hff); // read-only, ignored
        bus_read(mid_pkg::REG_STATUS, mid_pkg::STAT_RST);
        bus_read(8'hfc, 8'h00); // unmapped
        bus_write(mid_pkg::REG_TABLO, 8'h00);
        bus_write(mid_pkg::REG_TABHI, 8'h01);
        $display("register port done");
        bus_write(mid_pkg::REG_CTRL, 8'h01);
        wait_pd(1'b1);
        check(wdtCount, 8'h01);
        bus_read(mid_pkg::REG_WORK, 8'hf7);
        bus_read(mid_pkg::REG_STATUS, 8'h13);
        $display("first run done");
        @(posedge mclk);
        wakeUp <= 1'b1;
        wait_pd(1'b0);
        wakeUp <= 1'b0;
        for (int i = 0; i < 100 && wdtCount !== 8'h02; i++) @(posedge mclk);
        repeat (12) @(posedge mclk); // let the call to 0x41 return before halting
        bus_write(mid_pkg::REG_CTRL, 8'h00);
        check(wdtCount, 8'h02);
        bus_read(mid_pkg::REG_WORK, 8'ha6);
        bus_read(mid_pkg::REG_STATUS, 8'h1a);
        $display("second run done");
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
